// >>> rtl/secp_regs.vh
// Constants of the serial EEPROM command and protection block.
// Assumes a 100 MHz core clock and a framer that reports link events.
`ifndef SECP_REGS_VH
`define SECP_REGS_VH

// ****************************************
// Command byte codes
// ****************************************
`define SECP_CMD_RAND_READ 8'h03
`define SECP_CMD_CUR_READ 8'h06
`define SECP_CMD_WRITE 8'h6c
`define SECP_CMD_LATCH_SET 8'h96
`define SECP_CMD_LATCH_CLR 8'h91
`define SECP_CMD_STAT_READ 8'h05
`define SECP_CMD_STAT_WRITE 8'h6e

// ****************************************
// Link event codes from the framer
// ****************************************
`define SECP_EV_NONE 3'h0
`define SECP_EV_START 3'h1
`define SECP_EV_BYTE 3'h2
`define SECP_EV_MACK 3'h3
`define SECP_EV_NOACK 3'h4
`define SECP_EV_STBY 3'h5

// ****************************************
// Status byte fields
// ****************************************
`define SECP_ST_BUSY 0
`define SECP_ST_LATCH 1
`define SECP_ST_PROT_LO 2
`define SECP_ST_PROT_HI 3
`define SECP_ST_RESET 8'h00
`define SECP_PROT_NONE 2'h0
`define SECP_PROT_QUART 2'h1
`define SECP_PROT_HALF 2'h2

// ****************************************
// Timing
// ****************************************
`define SECP_CLK_MHZ 100
`define SECP_TWC_US 5000
`define SECP_TWC_CYC (`SECP_TWC_US * `SECP_CLK_MHZ)

`endif

// >>> rtl/secp_top.v
// Command interpreter of a single-wire serial EEPROM, with its array,
// page buffer, status byte and the read-data FIFO towards the framer.
// Assumes a framer that decodes bits and reports events on a slow
// link clock; events and data are stable around each rising edge.
`timescale 1ns/1ps
`include "secp_regs.vh"
`default_nettype none

// ****************************************
// Read-data FIFO
// ****************************************
module secp_fifo #(
  parameter W = 8,
  parameter D = 8,
  parameter AW = 3
) (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Fill side
  input wire in_valid,
  output wire in_ready,
  input wire [W-1:0] in_data,
  // Drain side
  output wire out_valid,
  input wire out_ready,
  output wire [W-1:0] out_data
);
  reg [W-1:0] mem_ff [0:D-1]; // Entry storage
  reg [AW-1:0] wp_ff; // Write index
  reg [AW-1:0] rp_ff; // Read index
  reg [AW:0] cnt_ff; // Fill level
  wire push;
  wire pop;

  assign in_ready = (cnt_ff != D[AW:0]);
  assign out_valid = (cnt_ff != {(AW+1){1'b0}});
  assign out_data = mem_ff[rp_ff];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // Entry store, no reset needed on data
  always @(posedge clk) begin
    if (push) begin
      mem_ff[wp_ff] <= in_data;
    end
  end

  // Indices wrap at depth, so depth need not be a power of two
  always @(posedge clk) begin
    if (rst) begin
      wp_ff <= {AW{1'b0}};
      rp_ff <= {AW{1'b0}};
      cnt_ff <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wp_ff <= (wp_ff == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : wp_ff + 1'b1;
      end
      if (pop) begin
        rp_ff <= (rp_ff == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : rp_ff + 1'b1;
      end
      if (push & ~pop) begin
        cnt_ff <= cnt_ff + 1'b1;
      end else if (pop & ~push) begin
        cnt_ff <= cnt_ff - 1'b1;
      end
    end
  end
endmodule

// ****************************************
// Command interpreter top
// ****************************************
module secp_top #(
  parameter AW = 7,
  parameter TWC_CYC = `SECP_TWC_CYC,
  parameter FIFO_D = 8
) (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Link events from the framer, on its own clock
  input wire lnk_clk,
  input wire [2:0] lnk_evt,
  input wire [7:0] lnk_byte,
  // Read data towards the framer
  output wire tx_valid,
  input wire tx_ready,
  output wire [7:0] tx_data,
  // Answers towards the framer
  output wire slave_ack,
  output wire idle_mode,
  output wire [7:0] protect_status
);
  localparam DEPTH = 1 << AW;
  localparam TW = 24;
  // Command states
  localparam ST_STBY = 4'h0;
  localparam ST_CMD = 4'h1;
  localparam ST_ADH = 4'h2;
  localparam ST_ADL = 4'h3;
  localparam ST_RDAT = 4'h4;
  localparam ST_WDAT = 4'h5;
  localparam ST_SDAT = 4'h6;
  localparam ST_IDLE = 4'h7;

  // ****************************************
  // Link synchronisers and edge finder
  // ****************************************
  reg [11:0] s1_ff; // First stage, read only by second stage
  reg [11:0] s2_ff; // Second stage
  reg clk3_ff; // Previous synced link clock level
  wire ev_edge;
  wire [2:0] ev;
  wire [7:0] ev_byte;

  // All link inputs take the same two stages so they stay aligned
  always @(posedge clk) begin
    if (rst) begin
      s1_ff <= 12'h000;
      s2_ff <= 12'h000;
      clk3_ff <= 1'b0;
    end else begin
      s1_ff <= {lnk_clk, lnk_evt, lnk_byte};
      s2_ff <= s1_ff;
      clk3_ff <= s2_ff[11];
    end
  end

  assign ev_edge = s2_ff[11] & ~clk3_ff;
  assign ev = ev_edge ? s2_ff[10:8] : `SECP_EV_NONE;
  assign ev_byte = s2_ff[7:0];

  // ****************************************
  // State
  // ****************************************
  reg [3:0] st_ff; // Command state
  reg [7:0] cmd_ff; // Accepted command
  reg [7:0] byte_ff; // Last received byte
  reg got_ff; // Byte received, awaiting its ack
  reg [7:0] hi_ff; // Address high byte
  reg [AW-1:0] addr_ff; // Address counter
  reg wel_ff; // Write enable latch
  reg [1:0] bp_ff; // Protection bits
  reg busy_ff; // Internal write underway
  reg arr_ff; // Cycle programs the array
  reg [TW-1:0] tmr_ff; // Write cycle timer
  reg [AW-5:0] page_ff; // Page of buffered data
  reg [127:0] buf_ff; // Page buffer bytes
  reg [15:0] bv_ff; // Page buffer valid bits
  reg pend_ff; // Byte waiting to enter FIFO
  reg pstat_ff; // Pending byte is the status
  reg sak_ff; // Acknowledge pulse
  reg [7:0] mem_ff [0:DEPTH-1]; // The array
  wire [7:0] status;
  wire fifo_rdy;
  wire [15:0] a16;
  wire [AW-1:0] a_new;
  wire [AW-1:0] a_wr_next;
  wire ack;
  wire prog;

  // Status byte, busy and latch read live, upper bits zero
  assign status = {4'h0, bp_ff, wel_ff, busy_ff};
  assign protect_status = status;
  assign slave_ack = sak_ff;
  assign idle_mode = (st_ff == ST_IDLE);
  assign ack = (ev == `SECP_EV_MACK) | (ev == `SECP_EV_NOACK);
  // Address bytes arrive high first; the width cuts the unused top
  assign a16 = (st_ff == ST_ADH) ? {byte_ff, 8'h00} : {hi_ff, byte_ff};
  assign a_new = a16[AW-1:0];
  // Page wrap: only the four low bits move during a write
  assign a_wr_next = {addr_ff[AW-1:4], addr_ff[3:0] + 4'h1};
  assign prog = busy_ff & (tmr_ff == {{(TW-1){1'b0}}, 1'b1});

  // Protection decode on the two top address bits
  function prot_hit;
    input [AW-1:0] a;
    input [1:0] bp;
    begin
      case (bp)
        `SECP_PROT_NONE: prot_hit = 1'b0;
        `SECP_PROT_QUART: prot_hit = &a[AW-1:AW-2];
        `SECP_PROT_HALF: prot_hit = a[AW-1];
        default: prot_hit = 1'b1;
      endcase
    end
  endfunction

  // ****************************************
  // Array programming at the end of a cycle
  // ****************************************
  // Held bytes go in together; no reset on array contents
  // Protected ranges start on page bounds, so one check covers a page
  wire page_prot; // Whole held page lies in a protected range
  wire [15:0] pwe; // Slot is programmed at the end of this cycle
  integer j;
  genvar gi;
  assign page_prot = prot_hit({page_ff, 4'h0}, bp_ff);
  generate
    for (gi = 0; gi < 16; gi = gi + 1) begin : g_prog
      assign pwe[gi] = prog & arr_ff & bv_ff[gi] & ~page_prot;
    end
  endgenerate

  // One process owns the array, so it has a single driver
  always @(posedge clk) begin
    for (j = 0; j < 16; j = j + 1) begin
      if (pwe[j]) begin
        mem_ff[{page_ff, j[3:0]}] <= buf_ff[j*8 +: 8];
      end
    end
  end

  // ****************************************
  // Command interpreter
  // ****************************************
  // A busy device cannot touch the buffer, so one clock owns it all
  always @(posedge clk) begin
    if (rst) begin
      st_ff <= ST_STBY;
      cmd_ff <= 8'h00;
      byte_ff <= 8'h00;
      got_ff <= 1'b0;
      hi_ff <= 8'h00;
      addr_ff <= {AW{1'b0}};
      wel_ff <= 1'b0;
      bp_ff <= 2'h0;
      busy_ff <= 1'b0;
      arr_ff <= 1'b0;
      tmr_ff <= {TW{1'b0}};
      page_ff <= {(AW-4){1'b0}};
      buf_ff <= 128'h0;
      bv_ff <= 16'h0000;
      pend_ff <= 1'b0;
      pstat_ff <= 1'b0;
      sak_ff <= 1'b0;
    end else begin
      sak_ff <= 1'b0;
      if (pend_ff & fifo_rdy) begin
        pend_ff <= 1'b0;
      end
      // Write cycle timer; the cycle frees the buffer as it ends
      if (busy_ff) begin
        tmr_ff <= tmr_ff - 1'b1;
        if (prog) begin
          busy_ff <= 1'b0;
          bv_ff <= 16'h0000;
        end
      end
      if (ev == `SECP_EV_STBY) begin
        // Standby ends any command; an unfinished write is dropped
        st_ff <= ST_STBY;
        got_ff <= 1'b0;
        if (~busy_ff) begin
          bv_ff <= 16'h0000;
        end
      end else if (ev != `SECP_EV_NONE) begin
        case (st_ff)
          ST_STBY: begin
            if (ev == `SECP_EV_START) begin
              st_ff <= ST_CMD;
              got_ff <= 1'b0;
            end
          end
          ST_IDLE: begin
            // Everything ignored until a standby pulse
          end
          default: begin
            if (ev == `SECP_EV_BYTE) begin
              // A second byte without an ack is a framing slip
              if (got_ff) begin
                st_ff <= ST_IDLE;
              end else begin
                byte_ff <= ev_byte;
                got_ff <= 1'b1;
                if (st_ff == ST_WDAT) begin
                  buf_ff[addr_ff[3:0]*8 +: 8] <= ev_byte;
                  bv_ff[addr_ff[3:0]] <= 1'b1;
                end
              end
            end else if (ack & ~got_ff & (st_ff != ST_RDAT)) begin
              // No-ack before any write data cancels the command
              st_ff <= (ev == `SECP_EV_NOACK) ? ST_STBY : ST_IDLE;
              bv_ff <= busy_ff ? bv_ff : 16'h0000;
            end else if (ack) begin
              got_ff <= 1'b0;
              case (st_ff)
                ST_CMD: begin
                  cmd_ff <= byte_ff;
                  case (byte_ff)
                    `SECP_CMD_LATCH_SET, `SECP_CMD_LATCH_CLR: begin
                      if (ev == `SECP_EV_NOACK) begin
                        wel_ff <= (byte_ff == `SECP_CMD_LATCH_SET);
                        sak_ff <= 1'b1;
                        st_ff <= ST_STBY;
                      end else begin
                        st_ff <= ST_IDLE;
                      end
                    end
                    `SECP_CMD_STAT_READ: begin
                      // Allowed even during a write cycle
                      if (ev == `SECP_EV_MACK) begin
                        sak_ff <= 1'b1;
                        pend_ff <= 1'b1;
                        pstat_ff <= 1'b1;
                        st_ff <= ST_RDAT;
                      end else begin
                        st_ff <= ST_STBY;
                      end
                    end
                    `SECP_CMD_RAND_READ, `SECP_CMD_WRITE, `SECP_CMD_CUR_READ, `SECP_CMD_STAT_WRITE: begin
                      if (busy_ff) begin
                        st_ff <= ST_IDLE;
                      end else if (ev == `SECP_EV_NOACK) begin
                        st_ff <= ST_STBY;
                      end else begin
                        sak_ff <= 1'b1;
                        if (byte_ff == `SECP_CMD_CUR_READ) begin
                          pend_ff <= 1'b1;
                          pstat_ff <= 1'b0;
                          st_ff <= ST_RDAT;
                        end else if (byte_ff == `SECP_CMD_STAT_WRITE) begin
                          st_ff <= ST_SDAT;
                        end else begin
                          st_ff <= ST_ADH;
                          bv_ff <= 16'h0000;
                        end
                      end
                    end
                    default: begin
                      st_ff <= ST_IDLE;
                    end
                  endcase
                end
                ST_ADH, ST_ADL: begin
                  addr_ff <= a_new;
                  if (st_ff == ST_ADH) begin
                    hi_ff <= byte_ff;
                  end
                  if (ev == `SECP_EV_NOACK) begin
                    st_ff <= ST_STBY;
                  end else begin
                    sak_ff <= 1'b1;
                    if (st_ff == ST_ADH) begin
                      st_ff <= ST_ADL;
                    end else if (cmd_ff == `SECP_CMD_WRITE) begin
                      page_ff <= a_new[AW-1:4];
                      st_ff <= ST_WDAT;
                    end else begin
                      pend_ff <= 1'b1;
                      pstat_ff <= 1'b0;
                      st_ff <= ST_RDAT;
                    end
                  end
                end
                ST_RDAT: begin
                  // Array reads step the counter on either ack
                  if (cmd_ff != `SECP_CMD_STAT_READ) begin
                    addr_ff <= addr_ff + 1'b1;
                  end
                  sak_ff <= 1'b1;
                  if (ev == `SECP_EV_MACK) begin
                    pend_ff <= 1'b1;
                  end else begin
                    st_ff <= ST_STBY;
                  end
                end
                ST_WDAT: begin
                  addr_ff <= a_wr_next;
                  sak_ff <= 1'b1;
                  if (ev == `SECP_EV_NOACK) begin
                    st_ff <= ST_STBY;
                    // Without the latch nothing is programmed
                    if (wel_ff) begin
                      busy_ff <= 1'b1;
                      arr_ff <= 1'b1;
                      tmr_ff <= TWC_CYC[TW-1:0];
                      wel_ff <= 1'b0;
                    end else begin
                      bv_ff <= 16'h0000;
                    end
                  end
                end
                ST_SDAT: begin
                  if (ev == `SECP_EV_NOACK) begin
                    sak_ff <= 1'b1;
                    st_ff <= ST_STBY;
                    // New protect bits show at once during the cycle
                    if (wel_ff) begin
                      bp_ff <= {byte_ff[`SECP_ST_PROT_HI], byte_ff[`SECP_ST_PROT_LO]};
                      busy_ff <= 1'b1;
                      arr_ff <= 1'b0;
                      tmr_ff <= TWC_CYC[TW-1:0];
                      wel_ff <= 1'b0;
                    end
                  end else begin
                    st_ff <= ST_IDLE;
                  end
                end
                default: begin
                  st_ff <= ST_IDLE;
                end
              endcase
            end else begin
              st_ff <= ST_IDLE;
            end
          end
        endcase
      end
    end
  end

  // ****************************************
  // Read data path
  // ****************************************
  // The byte is chosen when it enters, so status is fresh each time
  secp_fifo #(
    .W(8),
    .D(FIFO_D),
    .AW(3)
  ) u_fifo (
    .clk(clk),
    .rst(rst),
    .in_valid(pend_ff),
    .in_ready(fifo_rdy),
    .in_data(pstat_ff ? status : mem_ff[addr_ff]),
    .out_valid(tx_valid),
    .out_ready(tx_ready),
    .out_data(tx_data)
  );
endmodule

`default_nettype wire

// >>> sim/secp_master_model.sv
// Link master model: one event per 80 ns link period, reads drained.
// Assumes the bench calls ev only just after a falling clk edge.
`timescale 1ns/1ps
`default_nettype none
// ********
// Master model
// ********
module secp_master_model (
  // Core clock
  input wire logic clk,
  // Link events
  output logic lnk_clk,
  output logic [2:0] lnk_evt,
  output logic [7:0] lnk_byte,
  // Read data
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic [7:0] tx_data
);
  logic stall = 1'b0; // Bench holds reads back with this
  logic [7:0] rxq[$]; // Bytes taken from the device
  initial begin
    lnk_clk = 1'b0;
    lnk_evt = 3'h0;
    lnk_byte = 8'h5a;
  end
  // Ready moves off the sampling edge
  always @(negedge clk) begin
    tx_ready <= !stall;
  end
  // Take a byte on every accepted transfer
  always @(posedge clk) begin
    if (tx_valid && tx_ready) begin
      rxq.push_back(tx_data);
    end
  end
  // Code set while low, held across the rise; link clock idles low
  task automatic ev(input logic [2:0] e, input logic [7:0] b);
    lnk_evt = e;
    lnk_byte = b;
    repeat (4) @(negedge clk);
    lnk_clk = 1'b1;
    repeat (2) @(negedge clk);
    // Released while the clock is high, so a following call never
    // drives code or byte twice in one time step
    lnk_evt = 3'h0;
    lnk_byte = ~b; // Released byte lines must not keep the old value
    repeat (2) @(negedge clk);
    lnk_clk = 1'b0;
  endtask
endmodule
`default_nettype wire

// >>> sim/secp_properties.sv
// Port checker of the command block: ties answers to link events.
// Assumes a bind onto secp_top that hands on TWC_CYC.
`timescale 1ns/1ps
`default_nettype none
// ********
// Checker
// ********
module secp_properties #(
  parameter int TWC_CYC = 500000
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Link events
  input wire logic lnk_clk,
  input wire logic [2:0] lnk_evt,
  input wire logic [7:0] lnk_byte,
  // Read data and answers
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic [7:0] tx_data,
  input wire logic slave_ack,
  input wire logic idle_mode,
  input wire logic [7:0] protect_status
);
  logic [31:0] busy_cnt_ff; // Cycles the busy bit has stood
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Count busy cycles; too long for a repetition operator
  always @(posedge clk) begin
    if (rst || !protect_status[0]) begin
      busy_cnt_ff <= 32'h0;
    end else begin
      busy_cnt_ff <= busy_cnt_ff + 32'h1;
    end
  end
  property p_hi_zero; protect_status[7:4] == 4'h0; endproperty
  a_hi_zero: assert property (p_hi_zero) else $error("status top bits set");
  property p_rst_clr;
    disable iff (1'b0) rst |=> protect_status == 8'h00 && !tx_valid && !slave_ack && !idle_mode;
  endproperty
  a_rst_clr: assert property (p_rst_clr) else $error("reset state wrong");
  property p_idle_mute; idle_mode |-> !slave_ack; endproperty
  a_idle_mute: assert property (p_idle_mute) else $error("ack given in idle");
  // Event code is still on the lines two cycles before the answer
  property p_idle_exit; $fell(idle_mode) |-> $past(lnk_evt, 2) == 3'h5; endproperty
  a_idle_exit: assert property (p_idle_exit) else $error("idle left without standby");
  property p_busy_len; $fell(protect_status[0]) |-> busy_cnt_ff + 1 >= TWC_CYC && busy_cnt_ff <= TWC_CYC + 1;
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("write time wrong");
  property p_busy_latch; $rose(protect_status[0]) |-> !protect_status[1]; endproperty
  a_busy_latch: assert property (p_busy_latch) else $error("latch kept at write start");
  property p_latch_set; $rose(protect_status[1]) |-> $past(lnk_evt, 2) == 3'h4; endproperty
  a_latch_set: assert property (p_latch_set) else $error("latch set without no-ack");
  property p_prot_chg; $changed(protect_status[3:2]) |-> $past(lnk_evt, 2) == 3'h4; endproperty
  a_prot_chg: assert property (p_prot_chg) else $error("protect bits moved");
  property p_tx_hold; tx_valid && !tx_ready |=> tx_valid && $stable(tx_data); endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("read byte lost while stalled");
  c_idle: cover property ($rose(idle_mode));
  c_busy: cover property ($rose(protect_status[0]));
  c_stall: cover property (tx_valid && !tx_ready);
endmodule
`default_nettype wire

// >>> sim/tb_top.sv
// Self-checking bench of the command block with a link master model.
// Assumes secp_top, the checker and the master model are compiled.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin err_count++; $display("BAD %0t got %h exp %h", $time, a, e); end end
// ********
// Bench top
// ********
module tb_top;
  localparam int TWC = 200; // Short write time keeps the run brief
  logic clk, rst, lnk_clk, tx_valid, tx_ready, slave_ack, idle_mode;
  logic [2:0] lnk_evt;
  logic [7:0] lnk_byte, tx_data, protect_status;
  int err_count = 0;
  int n_compared = 0;
  int sak_n = 0; // Acknowledge pulses seen
  int i;
  logic [1:0] pv;
  secp_top #(.TWC_CYC(TWC)) uut (.clk, .rst, .lnk_clk, .lnk_evt, .lnk_byte, .tx_valid, .tx_ready, .tx_data,
    .slave_ack, .idle_mode, .protect_status);
  secp_master_model mst (.clk, .lnk_clk, .lnk_evt, .lnk_byte, .tx_valid, .tx_ready, .tx_data);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Count acknowledge pulses where they have settled
  always @(negedge clk) begin
    if (slave_ack === 1'b1) sak_n++;
  end
  // Watchdog, far beyond the expected run
  initial begin
    #150000;
    err_count++;
    $display("BAD %0t watchdog expired", $time);
    final_report();
  end
  task automatic final_report();
    if (err_count == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // Single link events, and a start with its command byte
  task automatic by(input logic [7:0] b); mst.ev(3'h2, b); endtask
  task automatic ma(); mst.ev(3'h3, 8'h00); endtask
  task automatic na(); mst.ev(3'h4, 8'h00); endtask
  task automatic sb(); mst.ev(3'h5, 8'h00); endtask
  task automatic cmd(input logic [7:0] c);
    mst.ev(3'h1, 8'h00);
    by(c);
  endtask
  // Latch set or clear, closed by no-ack
  task automatic latch(input logic on);
    cmd(on ? 8'h96 : 8'h91);
    na();
  endtask
  // Command and both address bytes, each acknowledged
  task automatic addr(input logic [7:0] c, input logic [7:0] a);
    cmd(c);
    ma();
    by(8'h00);
    ma();
    by(a);
    ma();
  endtask
  // Page write of n bytes counting up from d
  task automatic wr(input logic [7:0] a, input int n, input logic [7:0] d);
    int k;
    latch(1'b1);
    addr(8'h6c, a);
    for (k = 0; k < n; k++) begin
      by(d + 8'(k));
      if (k == n - 1) na(); else ma();
    end
  endtask
  // Random read of n bytes
  task automatic rd(input logic [7:0] a, input int n);
    addr(8'h03, a);
    repeat (n - 1) ma();
    na();
  endtask
  // Bounded wait for the write cycle to end
  task automatic idle_wait();
    int k;
    for (k = 0; k < 400 && protect_status[0] !== 1'b0; k++) @(negedge clk);
    `CHK(protect_status[0], 1'b0)
  endtask
  // Next byte the master took
  task automatic pop(input logic [7:0] e);
    int k;
    logic [7:0] g;
    for (k = 0; k < 50 && mst.rxq.size() == 0; k++) @(negedge clk);
    g = mst.rxq.size() > 0 ? mst.rxq.pop_front() : 8'hxx;
    `CHK(g, e)
  endtask
  initial begin
    rst = 1'b1;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    `CHK(protect_status, 8'h00)
    latch(1'b1);
    `CHK(protect_status, 8'h02)
    `CHK(sak_n, 1)
    latch(1'b0);
    `CHK(protect_status, 8'h00)
    cmd(8'h96);
    ma();
    `CHK(idle_mode, 1'b1)
    `CHK(sak_n, 2)
    na();
    `CHK(protect_status, 8'h00)
    sb();
    `CHK(idle_mode, 1'b0)
    // An undecoded command byte sends the device idle
    cmd(8'h6d);
    na();
    `CHK(idle_mode, 1'b1)
    sb();
    // Wrapping write, then a poll and a refused write while busy
    wr(8'h6e, 3, 8'ha0);
    cmd(8'h05);
    ma();
    na();
    pop(8'h01);
    cmd(8'h6c);
    ma();
    `CHK(idle_mode, 1'b1)
    sb();
    idle_wait();
    `CHK(protect_status, 8'h00)
    // Writes cut short by standby and by an early no-ack
    latch(1'b1);
    addr(8'h6c, 8'h6e);
    by(8'hee);
    sb();
    `CHK(protect_status[0], 1'b0)
    addr(8'h6c, 8'h6f);
    na();
    `CHK(protect_status[0], 1'b0)
    rd(8'h6e, 2);
    pop(8'ha0);
    pop(8'ha1);
    rd(8'h60, 1);
    pop(8'ha2);
    addr(8'h03, 8'h6e);
    sb();
    pop(8'ha0);
    cmd(8'h06);
    ma();
    ma();
    na();
    pop(8'ha0);
    pop(8'ha1);
    // Every protect code, ending on the upper quarter
    for (i = 0; i < 4; i++) begin
      pv = 2'(i ^ 2);
      latch(1'b1);
      cmd(8'h6e);
      ma();
      by({4'h0, pv, 2'b00});
      na();
      `CHK(protect_status, {4'h0, pv, 2'b01})
      idle_wait();
    end
    latch(1'b1);
    cmd(8'h6e);
    ma();
    by(8'h0c);
    ma();
    `CHK(idle_mode, 1'b1)
    sb();
    `CHK(protect_status, 8'h06)
    wr(8'h5f, 1, 8'h5a);
    idle_wait();
    wr(8'h60, 1, 8'h77);
    idle_wait();
    rd(8'h5f, 2);
    pop(8'h5a);
    pop(8'ha2);
    // Fill the read buffer with the master stalled, then drain it
    latch(1'b0);
    mst.stall = 1'b1;
    cmd(8'h05);
    repeat (8) ma();
    na();
    `CHK(tx_valid, 1'b1)
    mst.stall = 1'b0;
    repeat (8) pop(8'h04);
    final_report();
  end
endmodule
bind secp_top secp_properties #(.TWC_CYC(TWC_CYC)) chk (.clk, .rst, .lnk_clk, .lnk_evt, .lnk_byte, .tx_valid,
  .tx_ready, .tx_data, .slave_ack, .idle_mode, .protect_status);
`default_nettype wire
